// ### spm_pkg.sv
// Package for the shared port pin multiplexer
package spm_pkg;

  localparam int NUM_PINS = 30;

  // Per-pin function select codes (2 bits per pin)
  typedef enum logic [1:0] {
    FN_GPIO  = 2'h0,
    FN_PIXEL = 2'h1,
    FN_SYNC  = 2'h2,
    FN_ASYNC = 2'h3
  } spm_fn_t;

  // Register byte offsets
  localparam logic [11:0] OFF_FSEL_LO = 12'h000;
  localparam logic [11:0] OFF_FSEL_HI = 12'h004;
  localparam logic [11:0] OFF_GP_OUT  = 12'h008;
  localparam logic [11:0] OFF_GP_OE   = 12'h00C;
  localparam logic [11:0] OFF_GP_IN   = 12'h010;
  localparam logic [11:0] OFF_CTRL    = 12'h014;
  localparam logic [11:0] OFF_STAT    = 12'h018;

  // Reset values
  localparam logic [31:0] RST_FSEL    = 32'h0000_0000;
  localparam logic [29:0] RST_GP      = 30'h0000_0000;

  // Field positions
  localparam int CTRL_MASTER_BIT   = 0;
  localparam int STAT_MULTI_BIT    = 0;
  localparam int STAT_SEL_BIT      = 1;

  // Pin numbers
  localparam int PIN_SS_DAT  = 18;
  localparam int PIN_SS_RX   = 17;
  localparam int PIN_SS_CLK  = 16;
  localparam int PIN_SEL_IN  = 19;
  localparam int PIN_SEL_OUT = 22;

  // Pixel data from display unit
  typedef struct packed {
    logic [4:0] red;
    logic [4:0] green;
    logic [5:0] blue;
  } spm_pixel_t;

  // Synchronous serial unit signals
  typedef struct packed {
    logic master;
    logic dout;
    logic clk_out;
    logic clk_oe;
    logic sel_out_n;
  } spm_sync_t;

  // Asynchronous serial channel outputs
  typedef struct packed {
    logic [3:0] txd;
    logic [2:1] rts_n;
    logic [1:0] clk_out;
    logic [1:0] clk_oe;
  } spm_async_t;

endpackage : spm_pkg

// ### spm_pin_mux.sv
// Shared port pin multiplexer with APB register slave
// Function
// - Red pixel on pins 11-15, MSB 15
// - Green pixel on pins 6-10, MSB 10
// - Blue pixel on pins 0-5, MSB 5
// - Pin 18 data out master, in slave
// - Pin 17 data in master, out slave
// - Pin 16 clock out master, in slave
// - Slave selected only while pin 19 low
// - Master watches pin 19 for second master
// - Master drives select out on pin 22
// - Async transmit on pins 29,25,21,18
// - Async receive from pins 28,24,20,17
// - Request-to-send on pins 26 and 22
// - Clear-to-send on pins 27 and 23
// - Async serial clocks on pins 19,16
// - Thirty pin port, general I/O default
`timescale 1ns/100ps
`default_nettype none
module spm_pin_mux
(
  // Clock and reset
  input  wire logic                I_CLK,
  input  wire logic                I_SRST,
  // APB slave
  input  wire logic                I_PSEL,
  input  wire logic                I_PENABLE,
  input  wire logic                I_PWRITE,
  input  wire logic [11:0]         I_PADDR,
  input  wire logic [31:0]         I_PWDATA,
  output logic                     O_PREADY,
  output logic                     O_PSLVERR,
  output logic      [31:0]         O_PRDATA,
  // On-chip units
  input  wire spm_pkg::spm_pixel_t I_PIXEL,
  input  wire spm_pkg::spm_sync_t  I_SYNC,
  input  wire spm_pkg::spm_async_t I_ASYNC,
  output logic                     O_SYNC_DIN,
  output logic                     O_SYNC_CLK_IN,
  output logic                     O_SYNC_SELECTED,
  output logic      [3:0]          O_ASYNC_RXD,
  output logic      [2:1]          O_ASYNC_CTS_N,
  // Port pins
  input  wire logic [29:0]         I_PINS,
  output logic      [29:0]         O_PINS,
  output logic      [29:0]         O_PINS_OE
);

  logic [31:0] fsel_lo_q;
  logic [31:0] fsel_hi_q;
  logic [29:0] gp_out_q;
  logic [29:0] gp_oe_q;
  logic        master_q;
  logic        multi_q;
  logic [29:0] s1_q;
  logic [29:0] s2_q;
  logic [29:0] s3_q;
  logic [29:0] pin_in_q;
  logic [29:0] pin_d;
  logic [29:0] oe_d;
  logic [31:0] rdata_d;
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic        sel_low;

  function automatic spm_pkg::spm_fn_t fn_of(input int p,
                                             input logic [31:0] lo,
                                             input logic [31:0] hi);
    logic [1:0] f;
    f = (p < 16) ? lo[2*p +: 2] : hi[2*(p-16) +: 2];
    return spm_pkg::spm_fn_t'(f);
  endfunction : fn_of

  // Pin input synchroniser, three stages
  always_ff @(posedge I_CLK)
  begin
    s1_q <= I_PINS;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  // Filtered pin level, changes when stages 2 and 3 agree
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
      pin_in_q <= spm_pkg::RST_GP;
    else
      pin_in_q <= (s2_q & s3_q) | (pin_in_q & (s2_q ^ s3_q));
  end

  assign wr_en   = I_PSEL && I_PENABLE && I_PWRITE;
  assign rd_en   = I_PSEL && !I_PWRITE;
  assign addr_ok = (I_PADDR == spm_pkg::OFF_FSEL_LO) ||
                   (I_PADDR == spm_pkg::OFF_FSEL_HI) ||
                   (I_PADDR == spm_pkg::OFF_GP_OUT)  ||
                   (I_PADDR == spm_pkg::OFF_GP_OE)   ||
                   (I_PADDR == spm_pkg::OFF_GP_IN)   ||
                   (I_PADDR == spm_pkg::OFF_CTRL)    ||
                   (I_PADDR == spm_pkg::OFF_STAT);
  assign O_PREADY  = 1'b1;
  assign O_PSLVERR = I_PSEL && I_PENABLE && !addr_ok;

  // Function select registers
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      fsel_lo_q <= spm_pkg::RST_FSEL;
      fsel_hi_q <= spm_pkg::RST_FSEL;
    end
    else if (wr_en && I_PADDR == spm_pkg::OFF_FSEL_LO)
      fsel_lo_q <= I_PWDATA;
    else if (wr_en && I_PADDR == spm_pkg::OFF_FSEL_HI)
      fsel_hi_q <= {4'h0, I_PWDATA[27:0]};
  end

  // General I/O registers
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      gp_out_q <= spm_pkg::RST_GP;
      gp_oe_q  <= spm_pkg::RST_GP;
    end
    else if (wr_en && I_PADDR == spm_pkg::OFF_GP_OUT)
      gp_out_q <= I_PWDATA[29:0];
    else if (wr_en && I_PADDR == spm_pkg::OFF_GP_OE)
      gp_oe_q <= I_PWDATA[29:0];
  end

  // Second master detect, sticky, set wins over clear
  assign sel_low = !pin_in_q[spm_pkg::PIN_SEL_IN];
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
      multi_q <= 1'b0;
    else if (I_SYNC.master && sel_low &&
             fn_of(spm_pkg::PIN_SEL_IN, fsel_lo_q, fsel_hi_q) ==
             spm_pkg::FN_SYNC)
      multi_q <= 1'b1;
    else if (wr_en && I_PADDR == spm_pkg::OFF_STAT &&
             I_PWDATA[spm_pkg::STAT_MULTI_BIT])
      multi_q <= 1'b0;
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
      master_q <= 1'b0;
    else if (wr_en && I_PADDR == spm_pkg::OFF_CTRL)
      master_q <= I_PWDATA[spm_pkg::CTRL_MASTER_BIT];
  end

  // Read data mux
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    case (I_PADDR)
      spm_pkg::OFF_FSEL_LO: rdata_d = fsel_lo_q;
      spm_pkg::OFF_FSEL_HI: rdata_d = fsel_hi_q;
      spm_pkg::OFF_GP_OUT:  rdata_d = {2'h0, gp_out_q};
      spm_pkg::OFF_GP_OE:   rdata_d = {2'h0, gp_oe_q};
      spm_pkg::OFF_GP_IN:   rdata_d = {2'h0, pin_in_q};
      spm_pkg::OFF_CTRL:    rdata_d = {31'h0, master_q};
      spm_pkg::OFF_STAT:    rdata_d = {30'h0, O_SYNC_SELECTED, multi_q};
      default:              rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
      O_PRDATA <= 32'h0000_0000;
    else if (rd_en && !I_PENABLE)
      O_PRDATA <= rdata_d;
  end

  // Output mux per pin
  always_comb
  begin
    pin_d = gp_out_q;
    oe_d  = gp_oe_q;
    for (int p = 0; p < spm_pkg::NUM_PINS; p++)
    begin
      case (fn_of(p, fsel_lo_q, fsel_hi_q))
        spm_pkg::FN_GPIO:
        begin
          pin_d[p] = gp_out_q[p];
          oe_d[p]  = gp_oe_q[p];
        end
        spm_pkg::FN_PIXEL:
        begin
          oe_d[p] = (p <= 15);
          if (p >= 11 && p <= 15)
            pin_d[p] = I_PIXEL.red[p-11];
          else if (p >= 6 && p <= 10)
            pin_d[p] = I_PIXEL.green[p-6];
          else if (p <= 5)
            pin_d[p] = I_PIXEL.blue[p];
          else
            pin_d[p] = 1'b0;
        end
        spm_pkg::FN_SYNC:
        begin
          pin_d[p] = 1'b0;
          oe_d[p]  = 1'b0;
          if (p == spm_pkg::PIN_SS_DAT)
          begin
            pin_d[p] = I_SYNC.dout;
            oe_d[p]  = I_SYNC.master;
          end
          else if (p == spm_pkg::PIN_SS_RX)
          begin
            pin_d[p] = I_SYNC.dout;
            oe_d[p]  = !I_SYNC.master;
          end
          else if (p == spm_pkg::PIN_SS_CLK)
          begin
            pin_d[p] = I_SYNC.clk_out;
            oe_d[p]  = I_SYNC.master && I_SYNC.clk_oe;
          end
          else if (p == spm_pkg::PIN_SEL_OUT)
          begin
            pin_d[p] = I_SYNC.sel_out_n;
            oe_d[p]  = I_SYNC.master;
          end
        end
        spm_pkg::FN_ASYNC:
        begin
          pin_d[p] = 1'b0;
          oe_d[p]  = 1'b0;
          case (p)
            29: begin pin_d[p] = I_ASYNC.txd[3]; oe_d[p] = 1'b1; end
            25: begin pin_d[p] = I_ASYNC.txd[2]; oe_d[p] = 1'b1; end
            21: begin pin_d[p] = I_ASYNC.txd[1]; oe_d[p] = 1'b1; end
            18: begin pin_d[p] = I_ASYNC.txd[0]; oe_d[p] = 1'b1; end
            26: begin pin_d[p] = I_ASYNC.rts_n[2]; oe_d[p] = 1'b1; end
            22: begin pin_d[p] = I_ASYNC.rts_n[1]; oe_d[p] = 1'b1; end
            19:
            begin
              pin_d[p] = I_ASYNC.clk_out[1];
              oe_d[p]  = I_ASYNC.clk_oe[1];
            end
            16:
            begin
              pin_d[p] = I_ASYNC.clk_out[0];
              oe_d[p]  = I_ASYNC.clk_oe[0];
            end
            default: ;
          endcase
        end
        default:
        begin
          pin_d[p] = gp_out_q[p];
          oe_d[p]  = gp_oe_q[p];
        end
      endcase
    end
  end

  // Pin outputs from flip-flops
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      O_PINS    <= spm_pkg::RST_GP;
      O_PINS_OE <= spm_pkg::RST_GP;
    end
    else
    begin
      O_PINS    <= pin_d;
      O_PINS_OE <= oe_d;
    end
  end

  // Inputs routed to units
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      O_SYNC_DIN      <= 1'b0;
      O_SYNC_CLK_IN   <= 1'b0;
      O_SYNC_SELECTED <= 1'b0;
      O_ASYNC_RXD     <= 4'hF;
      O_ASYNC_CTS_N   <= 2'h3;
    end
    else
    begin
      O_SYNC_DIN <= I_SYNC.master ? pin_in_q[spm_pkg::PIN_SS_RX] :
                                    pin_in_q[spm_pkg::PIN_SS_DAT];
      O_SYNC_CLK_IN <= pin_in_q[spm_pkg::PIN_SS_CLK];
      O_SYNC_SELECTED <= !I_SYNC.master && sel_low;
      O_ASYNC_RXD <= {pin_in_q[28], pin_in_q[24],
                      pin_in_q[20], pin_in_q[17]};
      O_ASYNC_CTS_N <= {pin_in_q[27], pin_in_q[23]};
    end
  end

  // Checks
  a_red_route: assert property (@(posedge I_CLK) disable iff (I_SRST)
    fn_of(15, fsel_lo_q, fsel_hi_q) == spm_pkg::FN_PIXEL
    |=> O_PINS[15] == $past(I_PIXEL.red[4]))
    else $error("red msb not on pin 15");
  a_green_route: assert property (@(posedge I_CLK) disable iff (I_SRST)
    fn_of(10, fsel_lo_q, fsel_hi_q) == spm_pkg::FN_PIXEL
    |=> O_PINS[10] == $past(I_PIXEL.green[4]))
    else $error("green msb not on pin 10");
  a_blue_route: assert property (@(posedge I_CLK) disable iff (I_SRST)
    fn_of(5, fsel_lo_q, fsel_hi_q) == spm_pkg::FN_PIXEL
    |=> O_PINS_OE[5] && (O_PINS[5] == $past(I_PIXEL.blue[5])))
    else $error("blue msb not on pin 5");
  a_data_dir: assert property (@(posedge I_CLK) disable iff (I_SRST)
    fn_of(18, fsel_lo_q, fsel_hi_q) == spm_pkg::FN_SYNC
    |=> O_PINS_OE[18] == $past(I_SYNC.master))
    else $error("pin 18 direction wrong");
  a_rx_dir: assert property (@(posedge I_CLK) disable iff (I_SRST)
    fn_of(17, fsel_lo_q, fsel_hi_q) == spm_pkg::FN_SYNC
    |=> O_PINS_OE[17] != $past(I_SYNC.master))
    else $error("pin 17 direction wrong");
  a_clk_slave: assert property (@(posedge I_CLK) disable iff (I_SRST)
    !I_SYNC.master |=> !O_PINS_OE[16] ||
    $past(fn_of(16, fsel_lo_q, fsel_hi_q)) != spm_pkg::FN_SYNC)
    else $error("slave drives clock");
  a_sel_out: assert property (@(posedge I_CLK) disable iff (I_SRST)
    fn_of(22, fsel_lo_q, fsel_hi_q) == spm_pkg::FN_SYNC && I_SYNC.master
    |=> O_PINS_OE[22] && O_PINS[22] == $past(I_SYNC.sel_out_n))
    else $error("select out not driven");
  a_async_tx: assert property (@(posedge I_CLK) disable iff (I_SRST)
    fn_of(29, fsel_lo_q, fsel_hi_q) == spm_pkg::FN_ASYNC
    |=> O_PINS[29] == $past(I_ASYNC.txd[3]))
    else $error("channel 3 tx not on pin 29");
  a_gpio_reset: assert property (@(posedge I_CLK)
    I_SRST |=> O_PINS_OE == 30'h0000_0000)
    else $error("pins driven after reset");

endmodule : spm_pin_mux
`default_nettype wire

// ### spm_far_model.sv
// External devices on the shared port pins
`timescale 1ns/100ps
`default_nettype none
module spm_far_model
(
  // Device pin side
  input  wire logic [29:0] i_pins,
  input  wire logic [29:0] i_pins_oe,
  // Levels driven by the external devices
  input  wire logic [29:0] i_ext,
  // Resolved pin levels
  output logic      [29:0] o_level
);
  // Outside parties drive clock, select and data where pins are released
  assign o_level = (i_pins_oe & i_pins) | (~i_pins_oe & i_ext);
endmodule : spm_far_model
`default_nettype wire

// ### spm_tb.sv
// Testbench for the shared port pin multiplexer
`timescale 1ns/100ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic [31:0] lo;
    logic [31:0] hi;
    logic [31:0] gout;
    logic [31:0] goe;
    logic [29:0] fv;
    logic [29:0] pins;
    logic [29:0] oe;
    logic [5:0]  rxc;
    logic        ain;
  } spm_row_t;
  logic               clk;
  logic               srst;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [11:0]        paddr;
  logic [31:0]        pwdata;
  logic               pready;
  logic               pslverr;
  logic [31:0]        prdata;
  spm_pkg::spm_sync_t sync_in;
  spm_pkg::spm_pixel_t pix;
  spm_pkg::spm_async_t asy;
  logic               din;
  logic               clk_in;
  logic               sel;
  logic [3:0]         rxd;
  logic [2:1]         cts_n;
  logic [29:0]        lvl;
  logic [29:0]        pins;
  logic [29:0]        oe;
  logic [29:0]        ext;
  logic [31:0]        rdat;
  logic               rerr;
  spm_row_t           r;
  int                 n_mismatch;
  int                 num_checks;
  int                 cycles;
  spm_row_t rows [4] = '{
    '{32'h0, 32'h0, 32'h2AAA_5555, 32'h3FFF_0000, 30'h0000_1234,
      30'h2AAA_0000, 30'h3FFF_0000, 6'h0, 1'b0},
    '{32'h5555_5555, 32'h0, 32'h0, 32'h0, 30'h3FFF_0000,
      30'h0000_9AAD, 30'h0000_FFFF, 6'h0, 1'b0},
    '{32'h0, 32'h0000_20AA, 32'h0, 32'h0, 30'h0008_0000,
      30'h0005_0000, 30'h0045_0000, 6'h0, 1'b0},
    '{32'h0, 32'hFFFF_FFFF, 32'h0, 32'h0, 30'h1092_0000,
      30'h2429_0000, 30'h266D_0000, 6'h2D, 1'b1}};

  spm_pin_mux u_spm_pin_mux (.I_CLK(clk), .I_SRST(srst), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .O_PRDATA(prdata), .I_PIXEL(pix), .I_SYNC(sync_in),
    .I_ASYNC(asy), .O_SYNC_DIN(din), .O_SYNC_CLK_IN(clk_in),
    .O_SYNC_SELECTED(sel), .O_ASYNC_RXD(rxd), .O_ASYNC_CTS_N(cts_n),
    .I_PINS(lvl), .O_PINS(pins), .O_PINS_OE(oe));
  spm_far_model u_spm_far_model (.i_pins(pins), .i_pins_oe(oe),
    .i_ext(ext), .o_level(lvl));

  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e,
                       input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdat);
  endtask : rdchk

  task automatic settle;
    repeat (8) @(posedge clk);
  endtask : settle

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, ext} = '0;
    {n_mismatch, num_checks} = '0;
    sync_in = 5'h1E;
    pix = 16'h9AAD;
    asy = 10'h2AF;
    srst = 1'b1;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      r = rows[i];
      apb(1'b1, spm_pkg::OFF_FSEL_LO, r.lo);
      apb(1'b1, spm_pkg::OFF_FSEL_HI, r.hi);
      apb(1'b1, spm_pkg::OFF_GP_OUT, r.gout);
      apb(1'b1, spm_pkg::OFF_GP_OE, r.goe);
      ext <= r.fv;
      settle();
      chk("oe", {2'h0, r.oe}, {2'h0, oe});
      chk("pins", {2'h0, r.pins}, {2'h0, pins & r.oe});
      rdchk(spm_pkg::OFF_GP_IN, {2'h0, (r.oe & r.pins) | (~r.oe & r.fv)},
            "gp_in");
      rdchk(spm_pkg::OFF_FSEL_HI, r.hi & 32'h0FFF_FFFF, "fsel_hi");
      if (r.ain)
        chk("rx_cts", {26'h0, r.rxc}, {26'h0, rxd, cts_n});
      $display("row %0d done", i);
    end
    pix <= 16'h6552;
    asy <= 10'h150;
    apb(1'b1, spm_pkg::OFF_FSEL_LO, 32'h5555_5555);
    apb(1'b1, spm_pkg::OFF_CTRL, 32'h0000_0001);
    settle();
    chk("oe_pat", 32'h2664_FFFF, {2'h0, oe});
    chk("pins_pat", 32'h0244_6552, {2'h0, pins & oe});
    rdchk(spm_pkg::OFF_CTRL, 32'h0000_0001, "ctrl");
    $display("pattern test done");
    apb(1'b1, spm_pkg::OFF_FSEL_HI, 32'h0000_20AA);
    ext <= 30'h0002_0000;
    settle();
    chk("sync_din", 32'h1, {31'h0, din});
    chk("selected", 32'h0, {31'h0, sel});
    rdchk(spm_pkg::OFF_STAT, 32'h1, "stat");
    ext <= 30'h000A_0000;
    settle();
    apb(1'b1, spm_pkg::OFF_STAT, 32'h1);
    rdchk(spm_pkg::OFF_STAT, 32'h0, "stat");
    sync_in.master <= 1'b0;
    ext <= 30'h0005_0000;
    settle();
    chk("oe_slave", 32'h2_0000, {2'h0, oe & 30'h7_0000});
    chk("pin17", 32'h2_0000, {2'h0, pins & 30'h2_0000});
    chk("slv_in", 32'h7, {29'h0, din, clk_in, sel});
    ext <= 30'h0008_0000;
    settle();
    chk("slv_in", 32'h0, {29'h0, din, clk_in, sel});
    $display("sync tests done");
    apb(1'b0, 12'h01C, 32'h0);
    chk("slverr", 32'h1, {31'h0, rerr});
    chk("unmapped", 32'h0, rdat);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    chk("rst_out", 32'h0, {2'h0, oe | pins});
    chk("rst_in", 32'h3F, {26'h0, rxd, cts_n});
    srst <= 1'b0;
    rdchk(spm_pkg::OFF_FSEL_LO, 32'h0, "fsel_lo");
    rdchk(spm_pkg::OFF_GP_OE, 32'h0, "gp_oe");
    $display("reset test done");
    test_done();
  end
endmodule : testbench
`default_nettype wire
